// ===== include/ubg_pkg.sv
// Package with constants for the dual-channel baud generator and interrupt pin block.
// Notes on behaviour
// - FIFO off: transmit interrupt low with a byte held, high when empty; with RS485 set the code waits for whole transmitter empty.
// - FIFO on, no RS485: transmit interrupt high below trigger level or FIFO empty.
// - FIFO on, RS485: transmit interrupt high below trigger or whole transmitter empty.
// - Receive interrupt high with one byte held or FIFO above trigger, else low.
// - Baud generators run from the shared oscillator input; bus needs no oscillator.
// - Each channel owns its own prescaler and baud generator for transmit and receive.
// - Modem control bit 7 selects prescaler: clear divides by one, set by four.
// - Divisor programmable from one to 65537 minus one sixteenth (integer zero counts as 65536), steps of a sixteenth.
// - Reset divisor is one: low byte 0x01, high byte and fraction 0x00.
// - Integer divisor is high byte in bits 15:8 and low byte in 7:0.
// - Only four fraction bits exist; value n means n sixteenths.
// - Enhanced mode bit 7 set gives 16 samples per bit, clear gives 8.
// - In 8X mode an odd fraction may jitter bit time by one sixteenth.
// - Sampling clock paces transmit shifting and receive sampling of its channel.
package ubg_pkg;
  localparam int NUM_CHAN = 2;
  // Register offsets on the three address lines.
  localparam logic [2:0] OFS_DIV_LOW = 3'h0;
  localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
  localparam logic [2:0] OFS_DIV_FRAC = 3'h2;
  localparam logic [2:0] OFS_MODEM_CTRL = 3'h3;
  localparam logic [2:0] OFS_ENH_MODE = 3'h4;
  localparam logic [2:0] OFS_FIFO_CTRL = 3'h5;
  localparam logic [2:0] OFS_RS485_CTRL = 3'h6;
  localparam logic [2:0] OFS_STATUS = 3'h7;
  // Field positions.
  localparam int BIT_PRESCALE4 = 7;
  localparam int BIT_SAMPLE16 = 7;
  localparam int BIT_FIFO_EN = 0;
  localparam int BIT_RS485 = 3;
  localparam int BIT_ST_IRQ = 0;
  localparam int BIT_ST_TX = 1;
  localparam int BIT_ST_RX = 2;
  localparam int FRAC_W = 4;
  // Reset values.
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_DIV_FRAC = 8'h00;
  localparam logic RST_PRESCALE4 = 1'b0;
  localparam logic RST_SAMPLE16 = 1'b1;
  localparam logic RST_FIFO_EN = 1'b0;
  localparam logic RST_RS485 = 1'b0;
  // Timing counts.
  localparam logic [1:0] PRESCALE_DIV4_LAST = 2'h3;
  localparam logic [3:0] SAMPLES_16X_LAST = 4'hf;
  localparam logic [3:0] SAMPLES_8X_LAST = 4'h7;
  localparam logic [16:0] DIV_ZERO_AS = 17'h10000;
endpackage

// ===== hdl/ubg_chan_baud.sv
// Per-channel prescaler and fractional baud generator.
`timescale 1ns/100ps
module ubg_chan_baud
  import ubg_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Shared oscillator edge and channel settings
  input wire logic i_osc_tick,
  input wire logic i_pre4,
  input wire logic i_samp16,
  input wire logic [15:0] i_div_int,
  input wire logic [FRAC_W-1:0] i_div_frac,
  // Sampling clock and bit clock
  output logic o_sample_tick,
  output logic o_bit_tick
);
  typedef struct packed {
    logic [1:0] pre_cnt;
    logic [16:0] cnt;
    logic [FRAC_W-1:0] acc;
    logic stretch;
    logic [3:0] bit_cnt;
    logic sample_tick;
    logic bit_tick;
  } ubg_baud_s;

  ubg_baud_s s;
  ubg_baud_s next_s;
  logic pre_tick;
  logic [16:0] len;
  logic [FRAC_W:0] sum;

  always_comb begin
    next_s = s;
    next_s.sample_tick = 1'b0;
    next_s.bit_tick = 1'b0;
    pre_tick = 1'b0;
    // A zero integer part is taken as the top of the range.
    len = (i_div_int == 16'h0000) ? DIV_ZERO_AS : {1'b0, i_div_int};
    len = len + {16'h0000, s.stretch};
    sum = {1'b0, s.acc} + {1'b0, i_div_frac};
    if (i_osc_tick) begin
      if (!i_pre4 || s.pre_cnt == PRESCALE_DIV4_LAST) begin
        pre_tick = 1'b1;
        next_s.pre_cnt = 2'h0;
      end else begin
        next_s.pre_cnt = s.pre_cnt + 2'h1;
      end
    end
    if (pre_tick) begin
      // Compare with >= so that a smaller divisor written mid-period takes hold at once.
      if (s.cnt >= len - 17'h00001) begin
        next_s.cnt = 17'h00000;
        next_s.sample_tick = 1'b1;
        next_s.acc = sum[FRAC_W-1:0];
        next_s.stretch = sum[FRAC_W];
        if (s.bit_cnt >= (i_samp16 ? SAMPLES_16X_LAST : SAMPLES_8X_LAST)) begin
          // Eight periods cannot hold an odd count of sixteenths evenly, hence the jitter.
          next_s.bit_cnt = 4'h0;
          next_s.bit_tick = 1'b1;
        end else begin
          next_s.bit_cnt = s.bit_cnt + 4'h1;
        end
      end else begin
        next_s.cnt = s.cnt + 17'h00001;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_sample_tick = s.sample_tick;
  assign o_bit_tick = s.bit_tick;
endmodule

// ===== hdl/ubg_irq_level.sv
// Per-channel interrupt pin level from transmitter and receiver state.
`timescale 1ns/100ps
module ubg_irq_level
  import ubg_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Mode
  input wire logic i_fifo_en,
  input wire logic i_rs485,
  // Transmitter state
  input wire logic i_thr_empty,
  input wire logic i_tx_fifo_below_trig,
  input wire logic i_tx_fifo_empty,
  input wire logic i_tx_all_empty,
  // Receiver state
  input wire logic i_rx_byte_held,
  input wire logic i_rx_fifo_above_trig,
  // Levels
  output logic o_irq,
  output logic o_tx_lvl,
  output logic o_rx_lvl
);
  typedef struct packed {
    logic tx;
    logic rx;
    logic irq;
  } ubg_irq_s;

  ubg_irq_s s;
  ubg_irq_s next_s;

  always_comb begin
    next_s = s;
    if (!i_fifo_en) begin
      next_s.tx = i_rs485 ? i_tx_all_empty : i_thr_empty;
      next_s.rx = i_rx_byte_held;
    end else begin
      if (i_rs485) begin
        next_s.tx = i_tx_fifo_below_trig || i_tx_all_empty;
      end else begin
        next_s.tx = i_tx_fifo_below_trig || i_tx_fifo_empty;
      end
      next_s.rx = i_rx_fifo_above_trig;
    end
    next_s.irq = next_s.tx || next_s.rx;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_irq = s.irq;
  assign o_tx_lvl = s.tx;
  assign o_rx_lvl = s.rx;
endmodule

// ===== hdl/ubg_top.sv
// Dual-channel baud generator with interrupt pins behind an 8-bit strobed host bus.
`timescale 1ns/100ps
module ubg_top
  import ubg_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Host bus pins, inputs all asynchronous to i_clk_sys, outputs registered on it
  input wire logic i_cs_a_n,
  input wire logic i_cs_b_n,
  input wire logic i_ior_n,
  input wire logic i_iow_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  // Shared oscillator input, asynchronous
  input wire logic i_osc_input,
  // Transmitter and receiver state per channel, index 0 is channel A
  input wire logic [NUM_CHAN-1:0] i_thr_empty,
  input wire logic [NUM_CHAN-1:0] i_tx_fifo_below_trig,
  input wire logic [NUM_CHAN-1:0] i_tx_fifo_empty,
  input wire logic [NUM_CHAN-1:0] i_tx_all_empty,
  input wire logic [NUM_CHAN-1:0] i_rx_byte_held,
  input wire logic [NUM_CHAN-1:0] i_rx_fifo_above_trig,
  // Sampling and bit clocks per channel
  output logic [NUM_CHAN-1:0] o_sample_tick,
  output logic [NUM_CHAN-1:0] o_bit_tick,
  // Mode levels handed to the shifters
  output logic [NUM_CHAN-1:0] o_sample16,
  output logic [NUM_CHAN-1:0] o_fifo_en,
  output logic [NUM_CHAN-1:0] o_rs485,
  // Interrupt pins
  output logic o_irq_out_chan_a,
  output logic o_irq_out_chan_b
);
  typedef struct packed {
    // Two-stage synchronisers for every host bus pin and the oscillator.
    logic [1:0] cs_n_s1;
    logic [1:0] cs_n_s2;
    logic ior_n_s1;
    logic ior_n_s2;
    logic iow_n_s1;
    logic iow_n_s2;
    logic iow_n_d;
    logic [2:0] addr_s1;
    logic [2:0] addr_s2;
    logic [7:0] wdata_s1;
    logic [7:0] wdata_s2;
    logic osc_s1;
    logic osc_s2;
    logic osc_d;
    logic osc_tick;
    // Write capture loaded while the write strobe is low.
    logic [1:0] wr_sel;
    logic [2:0] wr_addr;
    logic [7:0] wr_data;
    // Channel registers.
    logic [NUM_CHAN-1:0][7:0] div_low;
    logic [NUM_CHAN-1:0][7:0] div_high;
    logic [NUM_CHAN-1:0][FRAC_W-1:0] div_frac;
    logic [NUM_CHAN-1:0] pre4;
    logic [NUM_CHAN-1:0] samp16;
    logic [NUM_CHAN-1:0] fifo_en;
    logic [NUM_CHAN-1:0] rs485;
    // Read path.
    logic [7:0] rdata;
    logic rd_oe;
  } ubg_top_s;

  localparam ubg_top_s RESET_S = '{
    cs_n_s1: 2'h3,
    cs_n_s2: 2'h3,
    ior_n_s1: 1'b1,
    ior_n_s2: 1'b1,
    iow_n_s1: 1'b1,
    iow_n_s2: 1'b1,
    iow_n_d: 1'b1,
    addr_s1: 3'h0,
    addr_s2: 3'h0,
    wdata_s1: 8'h00,
    wdata_s2: 8'h00,
    osc_s1: 1'b0,
    osc_s2: 1'b0,
    osc_d: 1'b0,
    osc_tick: 1'b0,
    wr_sel: 2'h0,
    wr_addr: 3'h0,
    wr_data: 8'h00,
    div_low: {NUM_CHAN{RST_DIV_LOW}},
    div_high: {NUM_CHAN{RST_DIV_HIGH}},
    div_frac: {NUM_CHAN{RST_DIV_FRAC[FRAC_W-1:0]}},
    pre4: {NUM_CHAN{RST_PRESCALE4}},
    samp16: {NUM_CHAN{RST_SAMPLE16}},
    fifo_en: {NUM_CHAN{RST_FIFO_EN}},
    rs485: {NUM_CHAN{RST_RS485}},
    rdata: 8'h00,
    rd_oe: 1'b0
  };

  ubg_top_s s;
  ubg_top_s next_s;
  logic [NUM_CHAN-1:0] irq;
  logic [NUM_CHAN-1:0] tx_lvl;
  logic [NUM_CHAN-1:0] rx_lvl;
  logic wr_done;
  logic rd_active;
  logic rd_chan;
  logic [7:0] rd_mux;

  // Selected channel readback, or the status of the channel's own levels.
  function automatic logic [7:0] reg_view(input ubg_top_s st, input logic ch,
                                          input logic [2:0] a, input logic irq_l,
                                          input logic tx_l, input logic rx_l);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      OFS_DIV_LOW: v = st.div_low[ch];
      OFS_DIV_HIGH: v = st.div_high[ch];
      OFS_DIV_FRAC: v = {4'h0, st.div_frac[ch]};
      OFS_MODEM_CTRL: v[BIT_PRESCALE4] = st.pre4[ch];
      OFS_ENH_MODE: v[BIT_SAMPLE16] = st.samp16[ch];
      OFS_FIFO_CTRL: v[BIT_FIFO_EN] = st.fifo_en[ch];
      OFS_RS485_CTRL: v[BIT_RS485] = st.rs485[ch];
      OFS_STATUS: begin
        v[BIT_ST_IRQ] = irq_l;
        v[BIT_ST_TX] = tx_l;
        v[BIT_ST_RX] = rx_l;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    next_s = s;
    // Synchronisers: only stage two is read by logic.
    next_s.cs_n_s1 = {i_cs_b_n, i_cs_a_n};
    next_s.cs_n_s2 = s.cs_n_s1;
    next_s.ior_n_s1 = i_ior_n;
    next_s.ior_n_s2 = s.ior_n_s1;
    next_s.iow_n_s1 = i_iow_n;
    next_s.iow_n_s2 = s.iow_n_s1;
    next_s.iow_n_d = s.iow_n_s2;
    next_s.addr_s1 = i_addr;
    next_s.addr_s2 = s.addr_s1;
    next_s.wdata_s1 = i_data;
    next_s.wdata_s2 = s.wdata_s1;
    // The oscillator is sampled, so it must stay below half of i_clk_sys.
    next_s.osc_s1 = i_osc_input;
    next_s.osc_s2 = s.osc_s1;
    next_s.osc_d = s.osc_s2;
    next_s.osc_tick = s.osc_s2 && !s.osc_d;

    // Select, address and data are caught while the strobe is low, so that a
    // chip select released with the strobe still names the right channel.
    if (!s.iow_n_s2) begin
      next_s.wr_sel = ~s.cs_n_s2;
      next_s.wr_addr = s.addr_s2;
      next_s.wr_data = s.wdata_s2;
    end
    wr_done = s.iow_n_s2 && !s.iow_n_d;

    // Both selects low writes both channels at once.
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      if (wr_done && s.wr_sel[ch]) begin
        case (s.wr_addr)
          OFS_DIV_LOW: next_s.div_low[ch] = s.wr_data;
          OFS_DIV_HIGH: next_s.div_high[ch] = s.wr_data;
          OFS_DIV_FRAC: next_s.div_frac[ch] = s.wr_data[FRAC_W-1:0];
          OFS_MODEM_CTRL: next_s.pre4[ch] = s.wr_data[BIT_PRESCALE4];
          OFS_ENH_MODE: next_s.samp16[ch] = s.wr_data[BIT_SAMPLE16];
          OFS_FIFO_CTRL: next_s.fifo_en[ch] = s.wr_data[BIT_FIFO_EN];
          OFS_RS485_CTRL: next_s.rs485[ch] = s.wr_data[BIT_RS485];
          default: next_s.rs485[ch] = s.rs485[ch];
        endcase
      end
    end

    // Reads: channel A wins when both are selected; reading both is not supported.
    rd_active = !s.ior_n_s2 && (s.cs_n_s2 != 2'h3);
    rd_chan = s.cs_n_s2[0];
    rd_mux = reg_view(s, rd_chan, s.addr_s2, irq[rd_chan], tx_lvl[rd_chan], rx_lvl[rd_chan]);
    next_s.rd_oe = rd_active;
    if (rd_active) begin
      next_s.rdata = rd_mux;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= RESET_S;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  // One generator and one interrupt level per channel.
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    ubg_chan_baud u_baud (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_osc_tick(s.osc_tick),
      .i_pre4(s.pre4[g]),
      .i_samp16(s.samp16[g]),
      .i_div_int({s.div_high[g], s.div_low[g]}),
      .i_div_frac(s.div_frac[g]),
      .o_sample_tick(o_sample_tick[g]),
      .o_bit_tick(o_bit_tick[g])
    );
    ubg_irq_level u_irq (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_fifo_en(s.fifo_en[g]),
      .i_rs485(s.rs485[g]),
      .i_thr_empty(i_thr_empty[g]),
      .i_tx_fifo_below_trig(i_tx_fifo_below_trig[g]),
      .i_tx_fifo_empty(i_tx_fifo_empty[g]),
      .i_tx_all_empty(i_tx_all_empty[g]),
      .i_rx_byte_held(i_rx_byte_held[g]),
      .i_rx_fifo_above_trig(i_rx_fifo_above_trig[g]),
      .o_irq(irq[g]),
      .o_tx_lvl(tx_lvl[g]),
      .o_rx_lvl(rx_lvl[g])
    );
  end

  assign o_data = s.rdata;
  assign o_data_oe = s.rd_oe;
  assign o_sample16 = s.samp16;
  assign o_fifo_en = s.fifo_en;
  assign o_rs485 = s.rs485;
  assign o_irq_out_chan_a = irq[0];
  assign o_irq_out_chan_b = irq[1];
endmodule

// ===== testbench/ubg_top_sva.sv
// Checker for the baud generator and interrupt pin top, bound to its ports.
`timescale 1ns/100ps
module ubg_top_sva
  import ubg_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Host bus
  input wire logic i_cs_a_n,
  input wire logic i_cs_b_n,
  input wire logic i_ior_n,
  input wire logic i_iow_n,
  input wire logic o_data_oe,
  // Channel state
  input wire logic [NUM_CHAN-1:0] i_thr_empty,
  input wire logic [NUM_CHAN-1:0] i_tx_fifo_below_trig,
  input wire logic [NUM_CHAN-1:0] i_tx_fifo_empty,
  input wire logic [NUM_CHAN-1:0] i_tx_all_empty,
  input wire logic [NUM_CHAN-1:0] i_rx_byte_held,
  input wire logic [NUM_CHAN-1:0] i_rx_fifo_above_trig,
  // Generated clocks, modes and pins
  input wire logic [NUM_CHAN-1:0] o_sample_tick,
  input wire logic [NUM_CHAN-1:0] o_bit_tick,
  input wire logic [NUM_CHAN-1:0] o_sample16,
  input wire logic [NUM_CHAN-1:0] o_fifo_en,
  input wire logic [NUM_CHAN-1:0] o_rs485,
  input wire logic o_irq_out_chan_a,
  input wire logic o_irq_out_chan_b
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  function automatic logic lvl(input logic fe, rs, te, tb, tfe, ta, rh, ra);
    return (fe ? (tb | (rs ? ta : tfe)) : (rs ? ta : te)) | (fe ? ra : rh);
  endfunction
  logic [NUM_CHAN-1:0] lv;
  logic [1:0] up;
  logic [4:0] scnt;
  logic schg;
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_lv
    assign lv[g] = lvl(o_fifo_en[g], o_rs485[g], i_thr_empty[g], i_tx_fifo_below_trig[g],
                       i_tx_fifo_empty[g], i_tx_all_empty[g], i_rx_byte_held[g],
                       i_rx_fifo_above_trig[g]);
  end
  // The first bit period after reset or a mode change has no defined length, so skip it.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up <= 2'h0;
      scnt <= 5'h00;
      schg <= 1'b1;
    end else begin
      up <= {up[0], 1'b1};
      if (o_bit_tick[0]) begin
        scnt <= 5'h00;
      end else if (o_sample_tick[0]) begin
        scnt <= scnt + 5'h01;
      end
      if ($changed(o_sample16[0])) begin
        schg <= 1'b1;
      end else if (o_bit_tick[0]) begin
        schg <= 1'b0;
      end
    end
  end
  property p_irq_a; up[1] |-> o_irq_out_chan_a == $past(lv[0]); endproperty
  a_irq_a: assert property (p_irq_a) else $error("channel A pin level wrong");
  property p_irq_b; up[1] |-> o_irq_out_chan_b == $past(lv[1]); endproperty
  a_irq_b: assert property (p_irq_b) else $error("channel B pin level wrong");
  property p_bit_co; o_bit_tick != 2'h0 |-> (o_bit_tick & ~o_sample_tick) == 2'h0; endproperty
  a_bit_co: assert property (p_bit_co) else $error("bit tick without sample");
  property p_tick_pulse; o_sample_tick[0] |=> !o_sample_tick[0]; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("sample tick too long");
  property p_bit_cnt;
    o_bit_tick[0] && !schg |-> scnt == ($past(o_sample16[0]) ? 5'h0f : 5'h07);
  endproperty
  a_bit_cnt: assert property (p_bit_cnt) else $error("samples per bit wrong");
  property p_oe_rise; $rose(o_data_oe) |-> $past(i_ior_n, 3) == 1'b0; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive without read");
  property p_oe_fall; i_ior_n [*5] |-> !o_data_oe; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("drive after read");
  property p_rd_resp; $fell(i_ior_n) && !(i_cs_a_n && i_cs_b_n) |-> ##[2:4] o_data_oe; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
  property p_mode_hold;
    i_iow_n [*6] |-> $stable(o_fifo_en) && $stable(o_rs485) && $stable(o_sample16);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved without write");
endmodule
bind ubg_top ubg_top_sva i_sva (.i_clk_sys, .i_rst_n, .i_cs_a_n, .i_cs_b_n, .i_ior_n,
  .i_iow_n, .o_data_oe, .i_thr_empty, .i_tx_fifo_below_trig, .i_tx_fifo_empty,
  .i_tx_all_empty, .i_rx_byte_held, .i_rx_fifo_above_trig, .o_sample_tick, .o_bit_tick,
  .o_sample16, .o_fifo_en, .o_rs485, .o_irq_out_chan_a, .o_irq_out_chan_b);

// ===== testbench/ubg_osc_model.sv
// Oscillator model feeding the shared clock input of both channels.
`timescale 1ns/100ps
module ubg_osc_model #(
  parameter int HALF_NS = 20
) (
  // Control
  input wire logic i_run,
  // Clock output
  output logic o_osc
);
  // The offset keeps edges away from system clock edges so period counts stay exact.
  initial begin
    o_osc = 1'b0;
    #3;
    forever begin
      #(HALF_NS);
      o_osc = i_run ? ~o_osc : 1'b0;
    end
  end
endmodule

// ===== testbench/ubg_top_tb.sv
// Self-checking bench for the dual baud generator and interrupt pin top.
`timescale 1ns/100ps
module ubg_top_tb;
  import ubg_pkg::*;
  logic i_clk_sys, i_rst_n, i_cs_a_n, i_cs_b_n, i_ior_n, i_iow_n, i_osc_input, osc_run;
  logic [2:0] i_addr;
  logic [7:0] i_data, o_data;
  logic o_data_oe, o_irq_out_chan_a, o_irq_out_chan_b;
  logic [1:0] i_thr_empty, i_tx_fifo_below_trig, i_tx_fifo_empty, i_tx_all_empty;
  logic [1:0] i_rx_byte_held, i_rx_fifo_above_trig;
  logic [1:0] o_sample_tick, o_bit_tick, o_sample16, o_fifo_en, o_rs485;
  int mismatches, comparisons, cycles;
  ubg_top i_dut (.i_clk_sys, .i_rst_n, .i_ce(1'b1), .i_cs_a_n, .i_cs_b_n, .i_ior_n,
    .i_iow_n, .i_addr, .i_data, .o_data, .o_data_oe, .i_osc_input, .i_thr_empty,
    .i_tx_fifo_below_trig, .i_tx_fifo_empty, .i_tx_all_empty, .i_rx_byte_held,
    .i_rx_fifo_above_trig, .o_sample_tick, .o_bit_tick, .o_sample16, .o_fifo_en,
    .o_rs485, .o_irq_out_chan_a, .o_irq_out_chan_b);
  ubg_osc_model i_osc (.i_run(osc_run), .o_osc(i_osc_input));
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  task automatic tally_and_finish;
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes are held well past the two-flop synchroniser so every access is seen once.
  task automatic bus_wr(input logic [1:0] sel_n, input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    {i_cs_b_n, i_cs_a_n} <= sel_n;
    i_addr <= a;
    i_data <= d;
    repeat (3) @(posedge i_clk_sys);
    i_iow_n <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    i_iow_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    {i_cs_b_n, i_cs_a_n} <= 2'h3;
    repeat (4) @(posedge i_clk_sys);
  endtask
  task automatic rd_chk(input logic [1:0] sel_n, input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    {i_cs_b_n, i_cs_a_n} <= sel_n;
    i_addr <= a;
    repeat (3) @(posedge i_clk_sys);
    i_ior_n <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk("read_enable", {31'h0, o_data_oe}, 32'h1);
    chk("read_data", {24'h0, o_data}, {24'h0, exp});
    @(posedge i_clk_sys);
    i_ior_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    {i_cs_b_n, i_cs_a_n} <= 2'h3;
    repeat (4) @(posedge i_clk_sys);
  endtask
  task automatic wait_tick(input int c);
    do @(negedge i_clk_sys); while (o_sample_tick[c] !== 1'b1);
  endtask
  // The oscillator period is five system clocks, so sixteen periods are an exact count.
  task automatic run_case(input int c, input logic [15:0] dv, input logic [3:0] fr,
                          input logic pre, input logic s16);
    logic [1:0] sel;
    logic [31:0] n, b, k;
    sel = (c == 0) ? 2'h2 : 2'h1;
    bus_wr(sel, OFS_DIV_LOW, dv[7:0]);
    bus_wr(sel, OFS_DIV_HIGH, dv[15:8]);
    bus_wr(sel, OFS_DIV_FRAC, {4'h0, fr});
    bus_wr(sel, OFS_MODEM_CTRL, {pre, 7'h00});
    bus_wr(sel, OFS_ENH_MODE, {s16, 7'h00});
    repeat (3) wait_tick(c);
    n = 0;
    b = 0;
    k = 0;
    while (k < 16) begin
      @(negedge i_clk_sys);
      n++;
      if (o_sample_tick[c]) k++;
      if (o_bit_tick[c]) b++;
    end
    chk("sample_period", n, (32'(dv) * 32'h10 + 32'(fr)) * 32'h5 * (pre ? 32'h4 : 32'h1));
    chk("bit_ticks", b, s16 ? 32'h1 : 32'h2);
    chk("sample16", {31'h0, o_sample16[c]}, {31'h0, s16});
  endtask
  function automatic logic exp_lvl(input logic fe, input logic rs, input logic [5:0] s);
    logic tx, rx;
    tx = fe ? (s[4] | (rs ? s[2] : s[3])) : (rs ? s[2] : s[5]);
    rx = fe ? s[0] : s[1];
    return tx | rx;
  endfunction
  initial begin
    {i_rst_n, i_ior_n, i_iow_n, i_cs_a_n, i_cs_b_n, osc_run} = 6'h1e;
    i_addr = 3'h0;
    i_data = 8'h00;
    {i_thr_empty, i_tx_fifo_below_trig, i_tx_fifo_empty} = 6'h00;
    {i_tx_all_empty, i_rx_byte_held, i_rx_fifo_above_trig} = 6'h00;
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    // Oscillator stopped: the bus must still answer.
    for (int c = 0; c < 2; c++) begin
      rd_chk(c == 0 ? 2'h2 : 2'h1, OFS_DIV_LOW, 8'h01);
      rd_chk(c == 0 ? 2'h2 : 2'h1, OFS_DIV_HIGH, 8'h00);
      rd_chk(c == 0 ? 2'h2 : 2'h1, OFS_DIV_FRAC, 8'h00);
    end
    @(negedge i_clk_sys);
    chk("ticks_idle", {30'h0, o_sample_tick}, 32'h0);
    bus_wr(2'h0, OFS_DIV_FRAC, 8'hff);
    rd_chk(2'h1, OFS_DIV_FRAC, 8'h0f);
    osc_run = 1'b1;
    run_case(0, 16'h0002, 4'h0, 1'b0, 1'b1);
    run_case(0, 16'h0003, 4'h4, 1'b0, 1'b0);
    run_case(0, 16'h0001, 4'hf, 1'b1, 1'b1);
    run_case(1, 16'h0005, 4'h9, 1'b0, 1'b1);
    run_case(1, 16'h0100, 4'h0, 1'b0, 1'b0);
    rd_chk(2'h2, OFS_DIV_FRAC, 8'h0f);
    for (int m = 0; m < 4; m++) begin
      bus_wr(2'h2, OFS_FIFO_CTRL, {7'h00, m[0]});
      bus_wr(2'h2, OFS_RS485_CTRL, {4'h0, m[1], 3'h0});
      bus_wr(2'h1, OFS_FIFO_CTRL, {7'h00, ~m[0]});
      bus_wr(2'h1, OFS_RS485_CTRL, {4'h0, ~m[1], 3'h0});
      chk("fifo_en", {30'h0, o_fifo_en}, {30'h0, ~m[0], m[0]});
      chk("rs485", {30'h0, o_rs485}, {30'h0, ~m[1], m[1]});
      for (int p = 0; p < 64; p++) begin
        @(posedge i_clk_sys);
        {i_thr_empty[0], i_tx_fifo_below_trig[0], i_tx_fifo_empty[0]} <= p[5:3];
        {i_tx_all_empty[0], i_rx_byte_held[0], i_rx_fifo_above_trig[0]} <= p[2:0];
        {i_thr_empty[1], i_tx_fifo_below_trig[1], i_tx_fifo_empty[1]} <= ~p[5:3];
        {i_tx_all_empty[1], i_rx_byte_held[1], i_rx_fifo_above_trig[1]} <= ~p[2:0];
        repeat (3) @(negedge i_clk_sys);
        chk("irq_a", {31'h0, o_irq_out_chan_a}, {31'h0, exp_lvl(m[0], m[1], p[5:0])});
        chk("irq_b", {31'h0, o_irq_out_chan_b}, {31'h0, exp_lvl(~m[0], ~m[1], ~p[5:0])});
      end
    end
    // Status is read-only, so the write to it must leave both channels alone.
    @(posedge i_clk_sys);
    i_rx_fifo_above_trig <= 2'h0;
    i_rx_byte_held <= 2'h2;
    bus_wr(2'h0, OFS_STATUS, 8'h00);
    rd_chk(2'h2, OFS_STATUS, 8'h03);
    rd_chk(2'h1, OFS_STATUS, 8'h05);
    rd_chk(2'h2, OFS_MODEM_CTRL, 8'h80);
    rd_chk(2'h1, OFS_MODEM_CTRL, 8'h00);
    rd_chk(2'h2, OFS_ENH_MODE, 8'h80);
    rd_chk(2'h1, OFS_ENH_MODE, 8'h00);
    rd_chk(2'h2, OFS_FIFO_CTRL, 8'h01);
    rd_chk(2'h2, OFS_RS485_CTRL, 8'h08);
    tally_and_finish();
  end
endmodule
